// file: rbm_top.sv
// reset-time boot and memory-mode selection core
//
// Summary of operation
// - mode C low full memory, high host
// - C,B,A 000 or 100: byte-load 32 words first
// - 010: no boot, fetch external location 0
// - 101: host loads, wait for program word 0
// - host mode, D=0: acknowledge actively driven
// - host mode, D=1: acknowledge open drain, pull-down
// - mode C pin usable as flag after reset
// - power-down: input with pull, output with buffer
// - every reset starts at vector 0x0000
`timescale 1ns/100ps
`include "rbm_regs.svh"
module rbm_top
  import rbm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        mode_a,
  input  wire logic        mode_b,
  input  wire logic        mode_d,
  input  wire logic        shared_flag_pin_in,
  output logic             shared_flag_pin_out,
  output logic             shared_flag_pin_oe,
  input  wire logic        flag_dir_out,
  input  wire logic        flag_out_value,
  input  wire logic        flag_powerdown,
  input  wire logic        flag_pull_fitted,
  output logic             flag_in_value,
  input  wire logic        byte_dma_word_done,
  input  wire logic        internal_dma_pm0_write,
  input  wire logic        host_ack_active,
  output logic             host_access_ack_n_out,
  output logic             host_access_ack_oe,
  output logic             full_memory_mode,
  output logic             host_mode,
  output logic             mode_d_latched,
  output logic             byte_dma_loader_req,
  output logic             cfg_invalid,
  output logic             exec_hold,
  output logic             exec_start,
  output logic             start_external,
  output logic [13:0]      start_addr
);

  // =========================================================
  // state record
  typedef struct packed {
    rbm_phase_t  phase;
    rbm_boot_t   boot;
    logic        host;
    logic        mode_d;
    logic        invalid;
    logic [5:0]  word_cnt;
    logic        hold;
    logic        start;
    logic        ext;
    logic [13:0] addr;
    logic        flag_out;
    logic        flag_oe;
    logic        flag_in;
    logic        ack_n;
    logic        ack_oe;
    logic        fm_mode;
    logic        byte_req;
  } rbm_state_t;

  rbm_state_t  st_reg;
  rbm_state_t  st_next;
  rbm_sync_if  sq ();

  logic        cap_a;
  logic        cap_b;
  logic        cap_c;
  logic        pd_dir;

  // =========================================================
  // pin synchronisers
  rbm_pin_sync u_sync (
    .ref_clk            (ref_clk),
    .mode_a             (mode_a),
    .mode_b             (mode_b),
    .shared_flag_pin_in (shared_flag_pin_in),
    .mode_d             (mode_d),
    .sq                 (sq.sync)
  );

  assign cap_a = sq.mode_level[`RBM_MODE_A_POS];
  assign cap_b = sq.mode_level[`RBM_MODE_B_POS];
  assign cap_c = sq.mode_level[`RBM_MODE_C_POS];

  // direction forced for power-down: a pull resistor holds an input,
  // a three-state buffer needs us driving so the pin cannot hover
  assign pd_dir = !flag_pull_fitted;

  // =========================================================
  // next-state logic
  always_comb begin
    st_next       = st_reg;
    st_next.start = 1'b0;
    unique case (st_reg.phase)
      // first edge after reset release: levels still show the reset-time pins
      RBM_ST_CAPTURE: begin
        st_next.host    = cap_c;
        st_next.fm_mode = !cap_c;
        st_next.mode_d  = sq.mode_level[`RBM_MODE_D_POS];
        st_next.invalid = 1'b0;
        st_next.addr    = `RBM_RESET_VECTOR;
        st_next.ext     = 1'b0;
        if (!cap_b && !cap_a) begin
          // host-mode byte boot relies on board address latching
          st_next.boot     = RBM_BOOT_BYTE;
          st_next.byte_req = 1'b1;
          st_next.word_cnt = `RBM_CNT_ZERO;
          st_next.phase    = RBM_ST_BYTE;
        end else if (cap_c && !cap_b && cap_a) begin
          st_next.boot  = RBM_BOOT_HOST;
          st_next.phase = RBM_ST_HOST;
        end else begin
          // 010 runs without boot; unlisted codes fall back to the same
          st_next.boot    = RBM_BOOT_NONE;
          st_next.invalid = !(!cap_c && cap_b && !cap_a);
          st_next.ext     = 1'b1;
          st_next.addr    = `RBM_EXT_START;
          st_next.hold    = 1'b0;
          st_next.start   = 1'b1;
          st_next.phase   = RBM_ST_RUN;
        end
      end
      // count loaded words; execution waits for the last one
      RBM_ST_BYTE: begin
        if (byte_dma_word_done) begin
          st_next.word_cnt = st_reg.word_cnt + `RBM_CNT_ONE;
          if (st_reg.word_cnt == (`RBM_BOOT_WORDS - `RBM_CNT_ONE)) begin
            st_next.byte_req = 1'b0;
            st_next.hold     = 1'b0;
            st_next.start    = 1'b1;
            st_next.phase    = RBM_ST_RUN;
          end
        end
      end
      // host fills memory at will; the write to program word 0 frees us
      RBM_ST_HOST: begin
        if (internal_dma_pm0_write) begin
          st_next.hold  = 1'b0;
          st_next.start = 1'b1;
          st_next.phase = RBM_ST_RUN;
        end
      end
      // configuration stays frozen until the next reset
      RBM_ST_RUN: begin
        st_next.phase = RBM_ST_RUN;
      end
    endcase

    // shared flag pin: released while the mode level is being sampled
    if (st_reg.phase == RBM_ST_CAPTURE) begin
      st_next.flag_oe = 1'b0;
    end else if (flag_powerdown) begin
      st_next.flag_oe = pd_dir;
    end else begin
      st_next.flag_oe  = flag_dir_out;
      st_next.flag_out = flag_out_value;
    end
    st_next.flag_in = sq.flag_level;

    // acknowledge pin, active low; undriven outside host mode
    if (st_next.host && st_reg.phase != RBM_ST_CAPTURE) begin
      if (!st_next.mode_d) begin
        st_next.ack_oe = 1'b1;
        st_next.ack_n  = !host_ack_active;
      end else begin
        // open drain lets several acknowledges share one wire
        st_next.ack_oe = host_ack_active;
        st_next.ack_n  = 1'b0;
      end
    end else begin
      st_next.ack_oe = 1'b0;
      st_next.ack_n  = 1'b1;
    end
  end

  // =========================================================
  // state register
  // reset values are constants only; hold and vector stand before any clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg          <= '0;
      st_reg.phase    <= RBM_ST_CAPTURE;
      st_reg.boot     <= RBM_BOOT_NONE;
      st_reg.hold     <= 1'b1;
      st_reg.addr     <= `RBM_RESET_VECTOR;
      st_reg.ack_n    <= 1'b1;
      st_reg.word_cnt <= `RBM_CNT_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // =========================================================
  // outputs, all straight from the state record
  // no gate sits between the record and a pin, so no output can glitch
  assign shared_flag_pin_out   = st_reg.flag_out;
  assign shared_flag_pin_oe    = st_reg.flag_oe;
  assign flag_in_value         = st_reg.flag_in;
  assign host_access_ack_n_out = st_reg.ack_n;
  assign host_access_ack_oe    = st_reg.ack_oe;
  assign full_memory_mode      = st_reg.fm_mode;
  assign host_mode             = st_reg.host;
  assign mode_d_latched        = st_reg.mode_d;
  assign byte_dma_loader_req   = st_reg.byte_req;
  assign cfg_invalid           = st_reg.invalid;
  assign exec_hold             = st_reg.hold;
  assign exec_start            = st_reg.start;
  assign start_external        = st_reg.ext;
  assign start_addr            = st_reg.addr;
endmodule

// file: rbm_regs.svh
// constants for the reset boot and memory-mode select block
`ifndef RBM_REGS_SVH
`define RBM_REGS_SVH

// boot counts
`define RBM_BOOT_WORDS      6'h20
`define RBM_CNT_ZERO        6'h00
`define RBM_CNT_ONE         6'h01

// start addresses
`define RBM_RESET_VECTOR    14'h0000
`define RBM_EXT_START       14'h0000

// mode pin positions inside the synchronised mode vector
`define RBM_MODE_A_POS      0
`define RBM_MODE_B_POS      1
`define RBM_MODE_C_POS      2
`define RBM_MODE_D_POS      3

`endif

// file: rbm_pkg.sv
// types shared by the reset boot and memory-mode select modules
package rbm_pkg;

  // =========================================================
  // sequencer phases, one-hot
  typedef enum logic [3:0] {
    RBM_ST_CAPTURE = 4'b0001,
    RBM_ST_BYTE    = 4'b0010,
    RBM_ST_HOST    = 4'b0100,
    RBM_ST_RUN     = 4'b1000
  } rbm_phase_t;

  // =========================================================
  // latched boot choice
  typedef enum logic [1:0] {
    RBM_BOOT_NONE = 2'b00,
    RBM_BOOT_BYTE = 2'b01,
    RBM_BOOT_HOST = 2'b10
  } rbm_boot_t;

endpackage

// file: rbm_sync_if.sv
// carrier of synchronised pin levels between the pin stage and the core
`timescale 1ns/100ps
interface rbm_sync_if;
  logic [3:0] mode_level;
  logic       flag_level;

  modport sync (output mode_level, output flag_level);
  modport core (input mode_level, input flag_level);
endinterface

// file: rbm_pin_sync.sv
// two-stage synchronisers for the mode pins and the shared flag pin
`timescale 1ns/100ps
module rbm_pin_sync
  import rbm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic mode_a,
  input  wire logic mode_b,
  input  wire logic shared_flag_pin_in,
  input  wire logic mode_d,
  rbm_sync_if.sync  sq
);

  // sync record: first and second stage side by side
  typedef struct packed {
    logic [4:0] stage1;
    logic [4:0] stage2;
  } rbm_sync_state_t;

  rbm_sync_state_t sy_reg;
  rbm_sync_state_t sy_next;

  // =========================================================
  // sync chain: pins into the first stage, first stage into the second
  always_comb begin
    sy_next.stage1 = {shared_flag_pin_in, mode_d, shared_flag_pin_in, mode_b, mode_a};
    sy_next.stage2 = sy_reg.stage1;
  end

  // no reset here on purpose: the chain must keep tracking the pins
  // while the chip reset is held, so the levels are ready at release
  always_ff @(posedge ref_clk) begin
    sy_reg <= sy_next;
  end

  // only the second stage leaves this module
  assign sq.mode_level = sy_reg.stage2[3:0];
  assign sq.flag_level = sy_reg.stage2[4];
endmodule

// file: rbm_top_assertions.sv
// checker for the reset boot and memory-mode select block
`timescale 1ns/100ps
module rbm_top_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        byte_dma_word_done,
  input wire logic        internal_dma_pm0_write,
  input wire logic        host_ack_active,
  input wire logic        host_access_ack_n_out,
  input wire logic        host_access_ack_oe,
  input wire logic        full_memory_mode,
  input wire logic        host_mode,
  input wire logic        mode_d_latched,
  input wire logic        byte_dma_loader_req,
  input wire logic        exec_hold,
  input wire logic        exec_start,
  input wire logic [13:0] start_addr
);
  logic [6:0] cnt_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // =========================================================
  // boot words taken; one boot per reset, so no clear needed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt_reg <= 7'h00;
    else if (byte_dma_loader_req && byte_dma_word_done) cnt_reg <= cnt_reg + 7'h01;
  end
  mode_excl_a: assert property (!exec_hold || byte_dma_loader_req |-> host_mode != full_memory_mode)
    else $error("mode not exactly one");
  byte_count_a: assert property ($fell(byte_dma_loader_req) |-> cnt_reg == 7'h20) else $error("boot count");
  byte_hold_a: assert property (byte_dma_loader_req |-> exec_hold) else $error("ran during boot");
  host_wait_a: assert property (host_mode && exec_hold && !byte_dma_loader_req && internal_dma_pm0_write
    |-> ##[1:2] exec_start) else $error("host boot not released");
  ack_drive_a: assert property (host_mode && !mode_d_latched |=> host_access_ack_oe
    && host_access_ack_n_out == !$past(host_ack_active)) else $error("ack not driven");
  ack_open_a: assert property (host_mode && mode_d_latched |=> !host_access_ack_n_out
    && host_access_ack_oe == $past(host_ack_active)) else $error("ack not open drain");
  ack_idle_a: assert property (!host_mode |-> !host_access_ack_oe) else $error("ack driven");
  start_vec_a: assert property (exec_start |-> !exec_hold && start_addr == 14'h0000 ##1 !exec_start)
    else $error("bad start");
  mode_hold_a: assert property (host_mode || full_memory_mode |=> $stable(host_mode)
    && $stable(mode_d_latched)) else $error("mode changed");
endmodule
bind rbm_top rbm_top_chk u_chk (
  .ref_clk                (ref_clk),
  .rst                    (rst),
  .byte_dma_word_done     (byte_dma_word_done),
  .internal_dma_pm0_write (internal_dma_pm0_write),
  .host_ack_active        (host_ack_active),
  .host_access_ack_n_out  (host_access_ack_n_out),
  .host_access_ack_oe     (host_access_ack_oe),
  .full_memory_mode       (full_memory_mode),
  .host_mode              (host_mode),
  .mode_d_latched         (mode_d_latched),
  .byte_dma_loader_req    (byte_dma_loader_req),
  .exec_hold              (exec_hold),
  .exec_start             (exec_start),
  .start_addr             (start_addr)
);

// file: rbm_board.sv
// board model: reset-time mode driver and pull-down on the shared flag pin
`timescale 1ns/100ps
module rbm_board (
  input  wire logic rst,
  input  wire logic mode_c_drive,
  input  wire logic flag_oe,
  input  wire logic flag_out,
  output logic      pin
);
  // driver enabled only in reset, then released to the pull-down (extra hardware fitted)
  assign pin = flag_oe ? flag_out : (rst ? mode_c_drive : 1'b0);
endmodule

// file: rbm_top_tb.sv
// testbench for the reset boot and memory-mode select block
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module rbm_top_tb;
  logic ref_clk = 0, rst = 1, ma = 0, mb = 0, mc = 0, md = 0, pin;
  logic dir = 0, fval = 0, pd = 0, pull = 1, wd = 0, pm0 = 0, act = 0;
  logic po, poe, fin, ackn, ackoe, fmm, hm, mdl, req, inv, hold, st, sx;
  logic [13:0] sa;
  int miscompares = 0, total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  rbm_top DUT (.ref_clk(ref_clk), .rst(rst), .mode_a(ma), .mode_b(mb), .mode_d(md),
    .shared_flag_pin_in(pin), .shared_flag_pin_out(po), .shared_flag_pin_oe(poe), .flag_dir_out(dir),
    .flag_out_value(fval), .flag_powerdown(pd), .flag_pull_fitted(pull), .flag_in_value(fin),
    .byte_dma_word_done(wd), .internal_dma_pm0_write(pm0), .host_ack_active(act),
    .host_access_ack_n_out(ackn), .host_access_ack_oe(ackoe), .full_memory_mode(fmm), .host_mode(hm),
    .mode_d_latched(mdl), .byte_dma_loader_req(req), .cfg_invalid(inv), .exec_hold(hold),
    .exec_start(st), .start_external(sx), .start_addr(sa));
  rbm_board u_board (.rst(rst), .mode_c_drive(mc), .flag_oe(poe), .flag_out(po), .pin(pin));
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // reset with the mode pins set as {d, c, b, a}
  task automatic do_reset(logic [3:0] m);
    {md, mc, mb, ma} = m;
    rst = 1;
    cyc(3);
    rst = 0;
    cyc(1);
  endtask
  // start pulse is one cycle wide, so poll every cycle, bounded
  task automatic wait_st();
    for (int i = 0; i < 4 && st !== 1'b1; i++) cyc(1);
    `CHK("exec_start", 1'b1, st)
    if (st !== 1'b1) finish_test();
  endtask
  // =========================================================
  // every pin code decoded after one reset each
  task automatic t_cfg();
    logic [2:0] c;
    logic b, h;
    for (int i = 0; i < 16; i++) begin
      do_reset(i[3:0]);
      c = i[2:0];
      b = (c == 3'h0 || c == 3'h4);
      h = (c == 3'h5);
      `CHK("host_mode", c[2], hm)
      `CHK("full_mem", ~c[2], fmm)
      `CHK("loader_req", b, req)
      `CHK("exec_hold", b | h, hold)
      `CHK("start_ext", ~(b | h), sx)
      `CHK("mode_d", i[3], mdl)
      `CHK("cfg_invalid", c == 3'h1 || c == 3'h3 || c > 3'h5, inv)
      `CHK("exec_start", ~(b | h), st)
      `CHK("start_addr", 14'h0000, sa)
      cyc(1);
      `CHK("ack_oe", c[2] & ~i[3], ackoe)
    end
  endtask
  // back-to-back boot words, pins moved mid-boot
  task automatic t_byte();
    do_reset(4'h0);
    ma = 1;
    md = 1;
    for (int k = 0; k < 32; k++) begin
      wd = 1;
      cyc(1);
      if (k == 30) `CHK("hold_31", 1'b1, hold)
    end
    wd = 0;
    wait_st();
    `CHK("loader_req", 1'b0, req)
    `CHK("hold_done", 1'b0, hold)
    `CHK("mode_d", 1'b0, mdl)
  endtask
  task automatic t_host();
    do_reset(4'h5);
    act = 1;
    cyc(2);
    `CHK("ack_n", 1'b0, ackn)
    act = 0;
    cyc(2);
    `CHK("ack_n", 1'b1, ackn)
    `CHK("hold_host", 1'b1, hold)
    pm0 = 1;
    cyc(1);
    pm0 = 0;
    wait_st();
    do_reset(4'hd);
    act = 1;
    cyc(2);
    `CHK("od_oe", 1'b1, ackoe)
    `CHK("od_n", 1'b0, ackn)
    act = 0;
    cyc(2);
    `CHK("od_off", 1'b0, ackoe)
  endtask
  // flag asked as output through reset: pin must stay released during capture
  task automatic t_flag();
    dir = 1;
    fval = 1;
    do_reset(4'h6);
    `CHK("flag_oe_cap", 1'b0, poe)
    cyc(2);
    `CHK("flag_oe", 1'b1, poe)
    `CHK("flag_pin", 1'b1, pin)
    cyc(2);
    `CHK("flag_in_hi", 1'b1, fin)
    dir = 0;
    cyc(4);
    `CHK("flag_in", 1'b0, fin)
    dir = 1;
    pd = 1;
    cyc(2);
    `CHK("pd_pull", 1'b0, poe)
    dir = 0;
    pull = 0;
    cyc(2);
    `CHK("pd_buf", 1'b1, poe)
    `CHK("pd_level", 1'b1, pin)
  endtask
  initial begin
    t_cfg();
    t_byte();
    t_host();
    t_flag();
    finish_test();
  end
endmodule
